/* File: hw/drfmi_core.sv */
// Purpose: Receive footer write masking, per-channel interrupt logic and address extension
// Assumes: Link, event and tie-off inputs are on clk; registers on a plain strobe port
// Notes:   Channel 0 is receive, 1 is transmit; ce low freezes every flip-flop
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Mask mode: words 4-6 written only if mask zero
// - Words 0-3 and 7 always written
// - Addresses extended to 36 bits, top zero
// - One interrupt output per channel, four sources
// - Channel enable plus source enables; fatal unmasked
// - Status of every source always readable
// - Write one clears maskable status, not fatal
// - Overflows or busy pointer write set error
// - Bus data error sets fatal, freezes link
// - Delay timer fires after quiet interval following packet
// - Divider ticks every N clocks, 10-bit N
// - Eight-bit delay timer fires after 256 ticks
// - Coalescing fire clears delay timer
// - Delay fire reloads coalescing counter
// - Counter loads tie-off at reset, field writable
// - Counter decrements per end-of-payload or descriptor end
// - Zero increments pending count, reloads counter
// - Interrupt while pending non-zero and enabled
// - Acknowledge write decrements pending count
// - Load strobe write reloads counter from field
module drfmi_core
  import drfmi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [31:0]       regRdData,
  input  wire logic              rxSrcRdyN,
  input  wire logic              rxEopN,
  input  wire logic              rxEofN,
  input  wire logic [31:0]       rxData,
  input  wire logic [3:0]        rxRem,
  output logic                   rxDstRdyN,
  input  wire logic              rxIrqOnEnd,
  input  wire logic              txEop,
  input  wire logic              txIrqOnEnd,
  input  wire logic              rxBusy,
  input  wire logic              txBusy,
  input  wire logic              busReadDataError,
  input  wire logic              busWriteDataError,
  input  wire logic [DIV_W-1:0]  rxTimerDivisorTieoff,
  input  wire logic [DIV_W-1:0]  txTimerDivisorTieoff,
  input  wire logic [COAL_W-1:0] rxCoalesceTieoff,
  input  wire logic [COAL_W-1:0] txCoalesceTieoff,
  input  wire logic [31:0]       descAddr,
  output logic      [35:0]       busAddr,
  output logic                   footWrValid,
  output logic      [2:0]        footWrIndex,
  output logic      [31:0]       footWrData,
  output logic                   rxIrq,
  output logic                   txIrq,
  output logic                   linkFreeze
);

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [1:0][31:0]        curDesc;
    logic [1:0][DIV_W-1:0]   divCnt;
    logic [1:0]              tick;
    logic [1:0][DLY_W-1:0]   dlyCnt;
    logic [1:0]              dlyArmed;
    logic [1:0][COAL_W-1:0]  coalCnt;
    logic [1:0][COAL_W-1:0]  coalField;
    logic [1:0][PEND_W-1:0]  pend;
    logic [1:0]              stDly;
    logic [1:0]              stCoal;
    logic [1:0]              stErr;
    logic [1:0]              stNmErr;
    logic [1:0]              irq;
    logic                    cfgLoaded;
    logic                    frozen;
    logic                    inFooter;
    logic [2:0]              footIdx;
    logic                    footWrValid;
    logic [2:0]              footWrIndex;
    logic [31:0]             footWrData;
    logic                    dstRdyN;
    logic [35:0]             busAddr;
    logic [31:0]             rdData;
  } drfmi_state_s;

  drfmi_state_s st;
  drfmi_state_s next_st;

  // Per-channel views of inputs and decoded events
  logic [1:0][DIV_W-1:0]  divisor;
  logic [1:0][COAL_W-1:0] coalTie;
  logic [1:0]             busy;
  logic [1:0]             eopEvt;
  logic [1:0]             endEvt;
  logic [1:0]             coalEvt;
  logic [1:0]             dlyFire;
  logic [1:0]             coalFire;
  logic [1:0]             ackWr;
  logic [1:0]             loadWr;
  logic [1:0]             curWr;
  logic [1:0]             chIrqEn;
  logic                   beat;
  logic                   footBeat;
  logic                   footWrite;
  logic                   busErr;

  assign divisor  = {txTimerDivisorTieoff, rxTimerDivisorTieoff};
  assign coalTie  = {txCoalesceTieoff, rxCoalesceTieoff};
  assign busy     = {txBusy, rxBusy};
  assign endEvt   = {txIrqOnEnd, rxIrqOnEnd};
  assign busErr   = busReadDataError | busWriteDataError;

  // Link beat needs both ready lines low; a frozen link accepts nothing
  assign beat     = !rxSrcRdyN && !st.dstRdyN && !st.frozen;
  assign footBeat = beat && st.inFooter;
  assign eopEvt   = {txEop, beat && !rxEopN};

  // Maskable footer words follow the mask; the rest always go to memory
  always_comb begin
    footWrite = 1'b1;
    if (st.ctrl[CTL_MASK_MODE] && st.footIdx >= FOOT_FIRST_MASKABLE &&
        st.footIdx <= FOOT_LAST_MASKABLE) begin
      footWrite = (rxRem == REM_WRITE);
    end
  end

  // Register write decode, one strobe per channel
  always_comb begin
    ackWr  = '0;
    loadWr = '0;
    curWr  = '0;
    if (regWrStb) begin
      ackWr[0]  = (regAddr == REG_RX_IRQ) && regWrData[IRQ_COAL];
      ackWr[1]  = (regAddr == REG_TX_IRQ) && regWrData[IRQ_COAL];
      loadWr    = (regAddr == REG_CHCTL) ? regWrData[1:0] : 2'b00;
      curWr[0]  = (regAddr == REG_RX_CURDESC);
      curWr[1]  = (regAddr == REG_TX_CURDESC);
    end
  end

  // Channel event decode, shared by the next-state logic and the checks
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      chIrqEn[ch] = st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_IRQ_EN];
      coalEvt[ch] = st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_USE_END] ?
                    endEvt[ch] : eopEvt[ch];
      // Counter fires on the event that takes it to zero
      coalFire[ch] = st.cfgLoaded && coalEvt[ch] &&
                     (st.coalCnt[ch] <= COAL_W'(1));
      // Quiet interval over: 256 ticks with no new packet
      dlyFire[ch] = st.dlyArmed[ch] && st.tick[ch] && (st.dlyCnt[ch] == DLY_LAST) &&
                    !eopEvt[ch] && !coalFire[ch];
    end
  end

  // Next state of the whole block
  always_comb begin
    logic [PEND_W-1:0] pendNext;
    logic              ovfCoal;
    logic              ovfDly;
    logic [31:0]       irqWord;
    pendNext = '0;
    ovfCoal  = 1'b0;
    ovfDly   = 1'b0;
    irqWord  = '0;
    next_st  = st;

    // Footer framing: eight words after the end-of-payload beat
    next_st.footWrValid = 1'b0;
    if (beat && !st.inFooter && !rxEopN) begin
      next_st.inFooter = 1'b1;
      next_st.footIdx  = '0;
    end else if (footBeat) begin
      next_st.footWrValid = footWrite;
      next_st.footWrIndex = st.footIdx;
      next_st.footWrData  = rxData;
      next_st.footIdx     = st.footIdx + 3'h1;
      if (!rxEofN || st.footIdx == FOOT_LAST) begin
        next_st.inFooter = 1'b0;
      end
    end

    // Upper address bits are fixed at zero
    next_st.busAddr = {ADDR_EXT, descAddr};

    // Bus data error: fatal flag on both channels, link stops for good
    if (busErr) begin
      next_st.frozen  = 1'b1;
      next_st.stNmErr = 2'b11;
    end
    next_st.dstRdyN = next_st.frozen;

    if (regWrStb && regAddr == REG_CTRL) begin
      next_st.ctrl = regWrData;
    end

    for (int ch = 0; ch < 2; ch++) begin
      // Divider tick once every N clocks
      next_st.tick[ch] = 1'b0;
      if (DIV_W'(st.divCnt[ch] + DIV_W'(1)) >= divisor[ch]) begin
        next_st.divCnt[ch] = '0;
        next_st.tick[ch]   = 1'b1;
      end else begin
        next_st.divCnt[ch] = st.divCnt[ch] + DIV_W'(1);
      end

      // Delay timer restarts on every packet and counts ticks while armed
      if (eopEvt[ch]) begin
        next_st.dlyCnt[ch]   = '0;
        next_st.dlyArmed[ch] = 1'b1;
      end else if (st.dlyArmed[ch] && st.tick[ch]) begin
        next_st.dlyCnt[ch] = st.dlyCnt[ch] + DLY_W'(1);
      end
      if (dlyFire[ch]) begin
        next_st.dlyArmed[ch] = 1'b0;
        next_st.stDly[ch]    = 1'b1;
        ovfDly = st.stDly[ch] && !ackWr[ch];
      end
      if (coalFire[ch]) begin
        next_st.dlyCnt[ch]   = '0;
        next_st.dlyArmed[ch] = 1'b0;
      end

      // Coalescing counter: tie-off loads it at reset release, events count it down
      if (!st.cfgLoaded) begin
        next_st.coalField[ch] = coalTie[ch];
        next_st.coalCnt[ch]   = coalTie[ch];
      end else if (coalFire[ch] || dlyFire[ch] || loadWr[ch]) begin
        next_st.coalCnt[ch] = st.coalField[ch];
      end else if (coalEvt[ch]) begin
        next_st.coalCnt[ch] = st.coalCnt[ch] - COAL_W'(1);
      end

      // Pending count: increment on fire, decrement on acknowledge
      pendNext = st.pend[ch];
      if (ackWr[ch] && pendNext != '0) begin
        pendNext = pendNext - PEND_W'(1);
      end
      if (coalFire[ch]) begin
        if (pendNext == PEND_FULL) begin
          ovfCoal = 1'b1;
        end else begin
          pendNext = pendNext + PEND_W'(1);
        end
      end
      next_st.pend[ch] = pendNext;

      // Write-one-to-clear on maskable status; a new event beats the clear
      if ((ch == 0 && regWrStb && regAddr == REG_RX_IRQ) ||
          (ch == 1 && regWrStb && regAddr == REG_TX_IRQ)) begin
        if (regWrData[IRQ_DLY]) next_st.stDly[ch] = dlyFire[ch];
        if (regWrData[IRQ_COAL]) next_st.stCoal[ch] = coalFire[ch];
        if (regWrData[IRQ_ERR]) next_st.stErr[ch] = 1'b0;
        if (regWrData[IRQ_FIELD_WE]) begin
          next_st.coalField[ch] = regWrData[IRQ_FIELD_LSB +: COAL_W];
        end
      end
      if (coalFire[ch]) next_st.stCoal[ch] = 1'b1;

      // Maskable errors: optional overflows and a pointer write while busy
      if ((ovfDly && st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_DLY_OVF_EN]) ||
          (ovfCoal && st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_COAL_OVF_EN]) ||
          (curWr[ch] && busy[ch])) begin
        next_st.stErr[ch] = 1'b1;
      end
      if (curWr[ch]) begin
        next_st.curDesc[ch] = regWrData;
      end
      ovfCoal = 1'b0;
      ovfDly  = 1'b0;
    end
    next_st.cfgLoaded = 1'b1;

    // Interrupt outputs follow the registered state of the next cycle
    for (int ch = 0; ch < 2; ch++) begin
      next_st.irq[ch] = next_st.stNmErr[ch] ||
        (next_st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_IRQ_EN] &&
         ((next_st.pend[ch] != '0 &&
           next_st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_COAL_EN]) ||
          (next_st.stDly[ch] && next_st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_DLY_EN]) ||
          (next_st.stErr[ch] && next_st.ctrl[CTL_CH_BASE + ch*CTL_CH_STRIDE + CTL_ERR_EN])));
    end

    // Read data for the cycle after the strobe, zero otherwise
    next_st.rdData = '0;
    if (regRdStb) begin
      case (regAddr)
        REG_CTRL:       next_st.rdData = st.ctrl;
        REG_RX_IRQ,
        REG_TX_IRQ: begin
          for (int ch = 0; ch < 2; ch++) begin
            if ((ch == 0) == (regAddr == REG_RX_IRQ)) begin
              irqWord[IRQ_DLY]   = st.stDly[ch];
              irqWord[IRQ_COAL]  = st.stCoal[ch];
              irqWord[IRQ_ERR]   = st.stErr[ch];
              irqWord[IRQ_NMERR] = st.stNmErr[ch];
              irqWord[IRQ_PEND_LSB +: PEND_W]  = st.pend[ch];
              irqWord[IRQ_FIELD_LSB +: COAL_W] = st.coalField[ch];
              irqWord[IRQ_COUNT_LSB +: COAL_W] = st.coalCnt[ch];
            end
          end
          next_st.rdData = irqWord;
        end
        REG_CHCTL:      next_st.rdData = {16'h0000, st.dlyCnt[1], st.dlyCnt[0]};
        REG_RX_CURDESC: next_st.rdData = st.curDesc[0];
        REG_TX_CURDESC: next_st.rdData = st.curDesc[1];
        default:        next_st.rdData = '0;
      endcase
    end

    // Clock enable low holds everything
    if (!ce) begin
      next_st = st;
    end
  end

  // State register; tie-offs are taken by the first enabled edge after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st         <= '0;
      st.ctrl    <= CTRL_RESET;
      st.dstRdyN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign regRdData   = st.rdData;
  assign rxDstRdyN   = st.dstRdyN;
  assign busAddr     = st.busAddr;
  assign footWrValid = st.footWrValid;
  assign footWrIndex = st.footWrIndex;
  assign footWrData  = st.footWrData;
  assign rxIrq       = st.irq[0];
  assign txIrq       = st.irq[1];
  assign linkFreeze  = st.frozen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_mask_skip;
    ce && footBeat && st.ctrl[CTL_MASK_MODE] && st.footIdx == 3'h5 && rxRem == REM_SKIP |=> !footWrValid;
  endproperty
  a_mask_skip: assert property (p_mask_skip) else $error("masked footer word written");
  property p_word7;
    ce && footBeat && st.footIdx == FOOT_LAST |=> footWrValid && footWrIndex == FOOT_LAST;
  endproperty
  a_word7: assert property (p_word7) else $error("footer word 7 not written");
  // Guarded by the load flag so the edge that releases reset starts no attempt
  property p_addr_ext;
    ce && st.cfgLoaded |=> busAddr[35:32] == ADDR_EXT && busAddr[31:0] == $past(descAddr);
  endproperty
  a_addr_ext: assert property (p_addr_ext) else $error("address extension wrong");
  property p_freeze;
    ce && busErr |=> linkFreeze && rxDstRdyN ##1 linkFreeze && st.stNmErr == 2'b11;
  endproperty
  a_freeze: assert property (p_freeze) else $error("bus error did not freeze link");
  property p_nm_sticky;
    st.stNmErr[0] |=> st.stNmErr[0] && rxIrq;
  endproperty
  a_nm_sticky: assert property (p_nm_sticky) else $error("fatal error cleared or unsignalled");
  property p_irq_pend;
    st.pend[0] != '0 && chIrqEn[0] && st.ctrl[CTL_CH_BASE + CTL_COAL_EN] |-> rxIrq;
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("pending count without interrupt");
  property p_ack;
    ce && ackWr[0] && st.pend[0] != '0 && !coalFire[0] |=> st.pend[0] == $past(st.pend[0]) - 4'h1;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not decrement");
  property p_dly_fire;
    ce && dlyFire[0] |=> st.stDly[0] && st.coalCnt[0] == $past(st.coalField[0]);
  endproperty
  a_dly_fire: assert property (p_dly_fire) else $error("delay fire missed status or reload");
  property p_coal_clr;
    ce && coalFire[0] |=> st.dlyCnt[0] == '0 && !st.dlyArmed[0] && st.stCoal[0];
  endproperty
  a_coal_clr: assert property (p_coal_clr) else $error("coalescing fire left delay timer");
  property p_busy_err;
    ce && curWr[1] && txBusy |=> st.stErr[1];
  endproperty
  a_busy_err: assert property (p_busy_err) else $error("busy pointer write not flagged");

endmodule : drfmi_core

`default_nettype wire

/* File: pkg/drfmi_pkg.sv */
// Purpose: Shared constants for the receive footer mask and interrupt block
// Assumes: One clock, registers reached over a plain address/strobe port
// Notes:   Channel index 0 is receive, 1 is transmit
package drfmi_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_RX_IRQ     = 8'h04;
  localparam logic [7:0] REG_TX_IRQ     = 8'h08;
  localparam logic [7:0] REG_CHCTL      = 8'h0C;
  localparam logic [7:0] REG_RX_CURDESC = 8'h10;
  localparam logic [7:0] REG_TX_CURDESC = 8'h14;

  // Control register: global bit, then one byte per channel
  localparam int CTL_MASK_MODE   = 0;
  localparam int CTL_CH_BASE     = 8;
  localparam int CTL_CH_STRIDE   = 8;
  localparam int CTL_IRQ_EN      = 0;
  localparam int CTL_DLY_EN      = 1;
  localparam int CTL_COAL_EN     = 2;
  localparam int CTL_ERR_EN      = 3;
  localparam int CTL_DLY_OVF_EN  = 4;
  localparam int CTL_COAL_OVF_EN = 5;
  localparam int CTL_USE_END     = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Channel interrupt register fields
  localparam int IRQ_DLY       = 0;
  localparam int IRQ_COAL      = 1;
  localparam int IRQ_ERR       = 2;
  localparam int IRQ_NMERR     = 3;
  localparam int IRQ_FIELD_WE  = 7;
  localparam int IRQ_PEND_LSB  = 8;
  localparam int IRQ_FIELD_LSB = 16;
  localparam int IRQ_COUNT_LSB = 24;

  // Footer layout and byte-valid masks (active low)
  localparam logic [2:0] FOOT_FIRST_MASKABLE = 3'h4;
  localparam logic [2:0] FOOT_LAST_MASKABLE  = 3'h6;
  localparam logic [2:0] FOOT_LAST           = 3'h7;
  localparam logic [3:0] REM_WRITE           = 4'h0;
  localparam logic [3:0] REM_SKIP            = 4'hF;

  // Timer and counter widths
  localparam int DIV_W   = 10;
  localparam int DLY_W   = 8;
  localparam int COAL_W  = 8;
  localparam int PEND_W  = 4;
  localparam logic [DLY_W-1:0]  DLY_LAST  = 8'hFF;
  localparam logic [PEND_W-1:0] PEND_FULL = 4'hF;
  localparam logic [3:0]        ADDR_EXT  = 4'h0;

endpackage : drfmi_pkg

/* File: verif/drfmi_link_src.sv */
// Purpose: Fabric-side sender of receive frames for the footer mask bench
// Assumes: A beat is taken on an edge where both ready lines are low
// Notes:   Released data shows the inverse of the last beat, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module drfmi_link_src (
  input  wire logic        clk,
  input  wire logic        dstRdyN,
  output var  logic        srcRdyN,
  output var  logic        eopN,
  output var  logic        eofN,
  output var  logic [31:0] data,
  output var  logic [3:0]  rem
);
  // Idle link at time zero
  initial begin
    srcRdyN = 1'b1;
    eopN    = 1'b1;
    eofN    = 1'b1;
    data    = 32'h0000_0000;
    rem     = 4'hF;
  end

  // Eop beat, then eight footer words; the first nSkip of words 4-6 are skipped
  task automatic send_frame(input int f, input int nSkip);
    int w;
    int n;
    for (w = -1; w < 8; w++) begin
      srcRdyN <= 1'b0;
      eopN    <= (w < 0) ? 1'b0 : 1'b1;
      eofN    <= (w == 7) ? 1'b0 : 1'b1;
      data    <= 32'(32'hF00D_0000 | (f << 8) | (w & 255));
      rem     <= (w >= 4 && w < 4 + nSkip) ? 4'hF : 4'h0;
      n = 0;
      @(posedge clk);
      // Bounded so a frozen link cannot hang the run
      while (dstRdyN !== 1'b0 && n < 100) begin
        n++;
        @(posedge clk);
      end
    end
    srcRdyN <= 1'b1;
    eopN    <= 1'b1;
    eofN    <= 1'b1;
    data    <= ~data;
    rem     <= ~rem;
  endtask : send_frame
endmodule : drfmi_link_src
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: Register-level bench for footer masking, coalescing, delay timer and errors
// Assumes: 200 MHz clock; receive divider tie-off of 2 gives a tick every 2 clocks
// Notes:   Expected values come from the package offsets and the tie-offs set here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import drfmi_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000, regRdData, r;
  logic        regWrStb = 1'b0, regRdStb = 1'b0;
  logic        rxSrcRdyN, rxEopN, rxEofN, rxDstRdyN;
  logic [31:0] rxData, descAddr = 32'hDEAD_BEEF, footWrData;
  logic [3:0]  rxRem;
  logic        rxIrqOnEnd = 1'b0, txEop = 1'b0, txIrqOnEnd = 1'b0, rxBusy = 1'b0, txBusy = 1'b0;
  logic        busReadDataError = 1'b0, busWriteDataError = 1'b0;
  logic [35:0] busAddr;
  logic        footWrValid, rxIrq, txIrq, linkFreeze;
  logic [2:0]  footWrIndex;
  logic [34:0] footQ[$];
  int          n_fail = 0, samples_checked = 0, f, w;

  always #2.5 clk = ~clk;

  drfmi_core u_drfmi_core (.clk(clk), .resetn(resetn), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxSrcRdyN(rxSrcRdyN),
    .rxEopN(rxEopN), .rxEofN(rxEofN), .rxData(rxData), .rxRem(rxRem), .rxDstRdyN(rxDstRdyN),
    .rxIrqOnEnd(rxIrqOnEnd), .txEop(txEop), .txIrqOnEnd(txIrqOnEnd), .rxBusy(rxBusy), .txBusy(txBusy),
    .busReadDataError(busReadDataError), .busWriteDataError(busWriteDataError),
    .rxTimerDivisorTieoff(10'h002), .txTimerDivisorTieoff(10'h3FF), .rxCoalesceTieoff(8'h04),
    .txCoalesceTieoff(8'h09), .descAddr(descAddr), .busAddr(busAddr), .footWrValid(footWrValid),
    .footWrIndex(footWrIndex), .footWrData(footWrData), .rxIrq(rxIrq), .txIrq(txIrq),
    .linkFreeze(linkFreeze));

  drfmi_link_src u_drfmi_link_src (.clk(clk), .dstRdyN(rxDstRdyN), .srcRdyN(rxSrcRdyN), .eopN(rxEopN),
    .eofN(rxEofN), .data(rxData), .rem(rxRem));

  // Collect every footer word sent to memory
  always @(posedge clk) begin
    if (footWrValid === 1'b1) footQ.push_back({footWrIndex, footWrData});
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    // Taken mid-cycle while it stands; the task ends on a rising edge
    @(negedge clk);
    d = regRdData;
    @(posedge clk);
  endtask : rd

  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog: the sequence needs about 800 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, r);
    chk(r, CTRL_RESET);
    rd(REG_RX_IRQ, r);
    chk(r[31:16], 16'h0404);
    chk(r[11:8], 4'h0);
    rd(8'h3C, r);
    chk(r, 32'h0000_0000);
    chk(busAddr, 36'h0_DEAD_BEEF);
    // Mask mode on, receive coalescing enabled; tie-off of 4 fires on the fourth frame
    wr(REG_CTRL, 32'h0000_0501);
    for (f = 0; f < 4; f++) begin
      u_drfmi_link_src.send_frame(f, f);
      repeat (3) @(posedge clk);
      chk(footQ.size(), 8 - f);
      for (w = 0; w < 8; w++)
        if ((w < 4 || w >= 4 + f) && footQ.size() > 0)
          chk(footQ.pop_front(), {w[2:0], 32'(32'hF00D_0000 | (f << 8) | w)});
    end
    rd(REG_RX_IRQ, r);
    chk({r[11:8], r[1]}, 5'h03);
    chk(rxIrq, 1'b1);
    wr(REG_RX_IRQ, 32'h0000_0003);
    rd(REG_RX_IRQ, r);
    chk({r[11:8], r[1]}, 5'h00);
    chk(rxIrq, 1'b0);
    wr(REG_RX_IRQ, 32'h0003_0080);
    wr(REG_CHCTL, 32'h0000_0001);
    rd(REG_RX_IRQ, r);
    chk(r[31:16], 16'h0303);
    // Delay timer only: 256 ticks of 2 clocks after the eop
    wr(REG_CTRL, 32'h0000_0301);
    u_drfmi_link_src.send_frame(7, 0);
    repeat (400) @(posedge clk);
    rd(REG_RX_IRQ, r);
    chk({r[31:24], r[0]}, 9'h004);
    repeat (250) @(posedge clk);
    rd(REG_RX_IRQ, r);
    chk({r[31:24], r[0]}, 9'h007);
    chk(rxIrq, 1'b1);
    wr(REG_RX_IRQ, 32'h0000_0001);
    rd(REG_RX_IRQ, r);
    chk(r[0], 1'b0);
    chk(rxIrq, 1'b0);
    // Transmit channel counts descriptor ends only, count of 1
    wr(REG_CTRL, 32'h0045_0301);
    wr(REG_TX_IRQ, 32'h0001_0080);
    wr(REG_CHCTL, 32'h0000_0002);
    for (f = 0; f < 2; f++) begin
      @(posedge clk);
      txEop <= 1'b1;
      @(posedge clk);
      txEop      <= 1'b0;
      txIrqOnEnd <= 1'b1;
      @(posedge clk);
      txIrqOnEnd <= 1'b0;
    end
    rd(REG_TX_IRQ, r);
    chk(r[11:8], 4'h2);
    chk(txIrq, 1'b1);
    wr(REG_TX_IRQ, 32'h0000_0002);
    rd(REG_TX_IRQ, r);
    chk({r[11:8], txIrq}, 5'h03);
    // Clock enable low: a field write in that window is lost
    ce <= 1'b0;
    wr(REG_RX_IRQ, 32'h0009_0080);
    ce <= 1'b1;
    rd(REG_RX_IRQ, r);
    chk(r[31:16], 16'h0303);
    // Pointer write while busy: status only, error source not enabled
    @(posedge clk);
    rxBusy <= 1'b1;
    txBusy <= 1'b1;
    wr(REG_RX_CURDESC, 32'h0000_1000);
    wr(REG_TX_CURDESC, 32'h0000_2000);
    rd(REG_RX_IRQ, r);
    chk({r[2], rxIrq}, 2'h2);
    rd(REG_TX_IRQ, r);
    chk(r[2], 1'b1);
    wr(REG_RX_IRQ, 32'h0000_0004);
    rd(REG_RX_IRQ, r);
    chk(r[2], 1'b0);
    rxBusy <= 1'b0;
    txBusy <= 1'b0;
    // Bus data error freezes the link and cannot be cleared by software
    busWriteDataError <= 1'b1;
    @(posedge clk);
    busWriteDataError <= 1'b0;
    rd(REG_RX_IRQ, r);
    chk({r[3], linkFreeze, rxDstRdyN, rxIrq}, 4'hF);
    wr(REG_RX_IRQ, 32'h0000_0008);
    rd(REG_RX_IRQ, r);
    chk(r[3], 1'b1);
    rd(REG_TX_IRQ, r);
    chk(r[3], 1'b1);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
